// *** src/tsr_defs.vh ***
// constants for the time slot readout encoder
`ifndef TSR_DEFS_VH
`define TSR_DEFS_VH

// apb register byte offsets
`define TSR_ADDR_CTRL    8'h00
`define TSR_ADDR_STAT    8'h04
`define TSR_ADDR_LIVE    8'h08

// control register fields and reset value
`define TSR_CTRL_FN_LO   0
`define TSR_CTRL_RNG_LO  2
`define TSR_CTRL_RST     4'h0

// idle levels of the synchronised pins: {neg, zero, meas, slots}
`define TSR_PIN_IDLE     13'h0bff

// status register field positions
`define TSR_ST_THOU      16
`define TSR_ST_OVER      17
`define TSR_ST_MINUS     18
`define TSR_ST_LAST      19

// measurement functions
`define TSR_FN_DCV       2'h0
`define TSR_FN_DCI       2'h1
`define TSR_FN_OHM       2'h2
`define TSR_FN_TEMP      2'h3

// counter limits: three decades and a divide by eight top digit
`define TSR_DEC_MAX      4'h9
`define TSR_TOP_MAX      3'h7
`define TSR_TOP_THOU     3'h1
`define TSR_TOP_OVER     3'h2

// row and column code levels
`define TSR_CODE_IDLE    4'h0
`define TSR_ROW_SKIP     4'h8
`define TSR_ROW_JUMP     4'h4
`define TSR_COL_PLUS     4'h1
`define TSR_COL_MINUS    4'h1
`define TSR_COL_MILLI    4'h3
`define TSR_COL_KILO     4'h4
`define TSR_COL_VOLT     4'h2
`define TSR_COL_CELS     4'h7
`define TSR_COL_AMP      4'h5
`define TSR_COL_OHM      4'h6
`define TSR_COL_DP_BASE  4'h1

// time slot numbers as decoded
`define TSR_SLOT_NONE    4'h0
`define TSR_SLOT_1       4'h1
`define TSR_SLOT_2       4'h2
`define TSR_SLOT_3       4'h3
`define TSR_SLOT_4       4'h4
`define TSR_SLOT_5       4'h5
`define TSR_SLOT_6       4'h6
`define TSR_SLOT_7       4'h7
`define TSR_SLOT_8       4'h8
`define TSR_SLOT_9       4'h9
`define TSR_SLOT_10      4'ha

`endif

// *** src/tsr_sync.v ***
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module tsr_sync #(
   parameter         W    = 1,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   input  wire         clk,
   input  wire         rst_b,
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);
   reg [W-1:0] meta;

   // first stage feeds only the second; reset to the pins' idle levels
   // so no false strobe or edge is seen as reset lifts
   always @(posedge clk) begin
      if (!rst_b) begin
         meta <= INIT;
         q    <= INIT;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule
`default_nettype wire

// *** src/tsr_encoder.v ***
// time slot readout encoder: counter, store, digit mux and row/col codes
//
// Contract
// - count 40 kHz clock in BCD decades, pulse terminal count at full count
// - make store strobe when ramp reaches zero after terminal count
// - store captures count at strobe; later counting leaves held value alone
// - held digits toward the digit mux are kept inverted, active low
// - thousand flag low when held count is at least 1000
// - over-range flag low only when held count is 2000 or more
// - strobe colliding with a counter advance is postponed one clock
// - mux selects one 1-2-4-8 digit at a time, addressed by time slots
// - digit converter enabled only during slots four through seven
// - column code follows binary weight of selected digit
// - slot four carries top digit, five to seven the rest descending
// - slot one carries decimal point position and over-range row code
// - slot eight sends prefix and volt/celsius, slot nine amp/ohm
// - function and range setting choose units, prefix and decimal point
// - plus sign in slot three for dc and temperature; minus adds current
// - minus flag low when measured input is negative
// - over-range adds row jump code in slot one
// - terminal count suppresses over-range code, so display blinks
// - zero top digit sends row skip in slot four
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "tsr_defs.vh"
module tsr_encoder (
   input  wire        clk,
   input  wire        rst_b,
   // apb slave
   input  wire [7:0]  paddr,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output reg         pslverr,
   // analog front end pins
   input  wire        meas_clk,
   input  wire        zero_cross_n,
   input  wire        vx_neg,
   // readout link pins
   input  wire [9:0]  slot_n,
   output reg  [3:0]  row_code,
   output reg  [3:0]  col_code,
   // status pins
   output reg  [3:0]  digit_n,
   output reg         thousand_n,
   output reg         over_n,
   output reg         minus_n,
   output reg         last_count,
   output reg         store_pulse
);

   // synchronised pins
   wire [12:0] pins_s;
   wire        meas_s;
   wire        zero_s;
   wire        neg_s;
   wire [9:0]  slot_s;

   // edge history and counter state
   reg         meas_d;
   reg         zero_d;
   reg  [3:0]  dec [0:2];
   reg  [2:0]  top;
   wire [3:0]  carry;
   wire        adv;
   wire        full;

   // store path
   reg         armed;
   reg         store_pend;
   wire        store_req;
   wire        capture;
   reg  [3:0]  held_n [0:2];
   reg  [3:0]  held_top_n;

   // control and readout
   reg  [3:0]  ctrl;
   wire [1:0]  fn;
   wire [1:0]  rng;
   wire [3:0]  slot;
   wire [3:0]  sel_n;
   reg  [3:0]  next_row;
   reg  [3:0]  next_col;
   reg  [31:0] next_rdata;
   reg         next_err;

   // all outside pins pass two flops before use
   tsr_sync #(
      .W    (13),
      .INIT (`TSR_PIN_IDLE)
   ) u_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .d     ({vx_neg, zero_cross_n, meas_clk, slot_n}),
      .q     (pins_s)
   );

   assign slot_s = pins_s[9:0];
   assign meas_s = pins_s[10];
   assign zero_s = pins_s[11];
   assign neg_s  = pins_s[12];
   assign fn     = ctrl[`TSR_CTRL_FN_LO+1:`TSR_CTRL_FN_LO];
   assign rng    = ctrl[`TSR_CTRL_RNG_LO+1:`TSR_CTRL_RNG_LO];

   // lowest active slot wins if the host ever overlaps two strobes
   function [3:0] slot_of;
      input [9:0] s_n;
      integer k;
      begin
         slot_of = `TSR_SLOT_NONE;
         for (k = 9; k >= 0; k = k - 1) begin
            if (!s_n[k]) begin
               slot_of = k[3:0] + 4'h1;
            end
         end
      end
   endfunction

   // digit mux: slot four top digit, then descending significance
   function [3:0] digit_sel;
      input [3:0] s;
      input [3:0] t_n;
      input [3:0] h2_n;
      input [3:0] h1_n;
      input [3:0] h0_n;
      begin
         case (s)
            `TSR_SLOT_4: digit_sel = t_n;
            `TSR_SLOT_5: digit_sel = h2_n;
            `TSR_SLOT_6: digit_sel = h1_n;
            `TSR_SLOT_7: digit_sel = h0_n;
            default:     digit_sel = 4'hf;
         endcase
      end
   endfunction

   // true for the slots that carry digits
   function is_digit_slot;
      input [3:0] s;
      begin
         is_digit_slot = (s >= `TSR_SLOT_4) && (s <= `TSR_SLOT_7);
      end
   endfunction

   // prefix and volt/celsius code for slot eight
   function [3:0] prefix_code;
      input [1:0] f;
      input [1:0] r;
      begin
         case (f)
            `TSR_FN_DCV:  prefix_code = (r == 2'h0) ?
                                        `TSR_COL_MILLI : `TSR_COL_VOLT;
            `TSR_FN_DCI:  prefix_code = (r == 2'h0) ?
                                        `TSR_COL_MILLI : `TSR_CODE_IDLE;
            `TSR_FN_OHM:  prefix_code = (r >= 2'h2) ?
                                        `TSR_COL_KILO : `TSR_CODE_IDLE;
            `TSR_FN_TEMP: prefix_code = `TSR_COL_CELS;
            default:      prefix_code = `TSR_CODE_IDLE;
         endcase
      end
   endfunction

   // edge memory of the synchronised clock and comparator
   always @(posedge clk) begin
      if (!rst_b) begin
         meas_d <= 1'b0;
         zero_d <= 1'b1;
      end else begin
         meas_d <= meas_s;
         zero_d <= zero_s;
      end
   end

   // one enable per rising edge of the measurement clock
   assign adv      = meas_s & ~meas_d;
   assign carry[0] = adv;

   // bcd decades, carry rippled combinationally
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_dec
         assign carry[gi+1] = carry[gi] & (dec[gi] == `TSR_DEC_MAX);
         always @(posedge clk) begin
            if (!rst_b) begin
               dec[gi] <= 4'h0;
            end else if (carry[gi]) begin
               dec[gi] <= (dec[gi] == `TSR_DEC_MAX) ? 4'h0 :
                          dec[gi] + 4'h1;
            end
         end
      end
   endgenerate

   // divide by eight top digit closes the conversion cycle
   always @(posedge clk) begin
      if (!rst_b) begin
         top <= 3'h0;
      end else if (carry[3]) begin
         top <= top + 3'h1;
      end
   end

   // terminal count stands for the whole last count period
   assign full = (top == `TSR_TOP_MAX) && (dec[2] == `TSR_DEC_MAX) &&
                 (dec[1] == `TSR_DEC_MAX) && (dec[0] == `TSR_DEC_MAX);

   always @(posedge clk) begin
      if (!rst_b) begin
         last_count <= 1'b0;
      end else begin
         last_count <= full;
      end
   end

   // arm on terminal count, fire on the first ramp zero crossing after it
   always @(posedge clk) begin
      if (!rst_b) begin
         armed <= 1'b0;
      end else if (last_count) begin
         armed <= 1'b1;
      end else if (store_req) begin
         armed <= 1'b0;
      end
   end

   assign store_req = armed & ~last_count & ~zero_s & zero_d;

   // a strobe landing on a counter advance waits one clock so the
   // captured count is settled, never half way through a ripple
   always @(posedge clk) begin
      if (!rst_b) begin
         store_pend <= 1'b0;
      end else begin
         store_pend <= (store_req | store_pend) & adv;
      end
   end

   assign capture = (store_req | store_pend) & ~adv;

   // holding registers: only a capture updates them
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_hold
         always @(posedge clk) begin
            if (!rst_b) begin
               held_n[gi] <= 4'hf;
            end else if (capture) begin
               held_n[gi] <= ~dec[gi];
            end
         end
      end
   endgenerate

   // top digit, flags and polarity are latched with the same strobe
   always @(posedge clk) begin
      if (!rst_b) begin
         held_top_n  <= 4'hf;
         thousand_n  <= 1'b1;
         over_n      <= 1'b1;
         minus_n     <= 1'b1;
         store_pulse <= 1'b0;
      end else begin
         store_pulse <= capture;
         if (capture) begin
            held_top_n <= ~{1'b0, top};
            thousand_n <= ~(top >= `TSR_TOP_THOU);
            over_n     <= ~(top >= `TSR_TOP_OVER);
            minus_n    <= ~neg_s;
         end
      end
   end

   // the host's slot pulses address the mux and qualify the codes
   assign slot  = slot_of(slot_s);
   assign sel_n = digit_sel(slot, held_top_n, held_n[2], held_n[1],
                            held_n[0]);

   // code table per slot; everything outside an active slot is idle
   always @* begin
      next_row = `TSR_CODE_IDLE;
      next_col = `TSR_CODE_IDLE;
      case (slot)
         `TSR_SLOT_1: begin
            next_col = `TSR_COL_DP_BASE + {2'h0, rng};
            if (!over_n && !last_count) begin
               next_row = `TSR_ROW_JUMP;
            end
         end
         `TSR_SLOT_3: begin
            if (fn != `TSR_FN_OHM) begin
               next_col = minus_n ? `TSR_COL_PLUS :
                          `TSR_COL_PLUS + `TSR_COL_MINUS;
            end
         end
         `TSR_SLOT_4: begin
            next_col = ~sel_n;
            if (!thousand_n) begin
               next_row = `TSR_CODE_IDLE;
            end else begin
               next_row = `TSR_ROW_SKIP;
            end
         end
         `TSR_SLOT_5, `TSR_SLOT_6, `TSR_SLOT_7: begin
            next_col = ~sel_n;
         end
         `TSR_SLOT_8: begin
            next_col = prefix_code(fn, rng);
         end
         `TSR_SLOT_9: begin
            case (fn)
               `TSR_FN_DCI: next_col = `TSR_COL_AMP;
               `TSR_FN_OHM: next_col = `TSR_COL_OHM;
               default:     next_col = `TSR_CODE_IDLE;
            endcase
         end
         default: begin
            next_row = `TSR_CODE_IDLE;
            next_col = `TSR_CODE_IDLE;
         end
      endcase
   end

   // registered link outputs, one clock behind the synchronised slot
   always @(posedge clk) begin
      if (!rst_b) begin
         row_code <= `TSR_CODE_IDLE;
         col_code <= `TSR_CODE_IDLE;
         digit_n  <= 4'hf;
      end else begin
         row_code <= next_row;
         col_code <= next_col;
         digit_n  <= is_digit_slot(slot) ? sel_n : 4'hf;
      end
   end

   // apb: zero wait states, read data captured in the setup phase
   assign pready = 1'b1;

   always @* begin
      next_rdata = 32'h0000_0000;
      next_err   = 1'b0;
      case (paddr)
         `TSR_ADDR_CTRL: begin
            next_rdata[3:0] = ctrl;
         end
         `TSR_ADDR_STAT: begin
            next_rdata[15:0] = ~{held_top_n, held_n[2], held_n[1],
                                 held_n[0]};
            next_rdata[`TSR_ST_THOU]  = thousand_n;
            next_rdata[`TSR_ST_OVER]  = over_n;
            next_rdata[`TSR_ST_MINUS] = minus_n;
            next_rdata[`TSR_ST_LAST]  = last_count;
         end
         `TSR_ADDR_LIVE: begin
            next_rdata[15:0] = {1'b0, top, dec[2], dec[1], dec[0]};
         end
         default: begin
            next_err = 1'b1;
         end
      endcase
   end

   // read data and error flop ahead of the access phase
   always @(posedge clk) begin
      if (!rst_b) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
         pslverr <= next_err |
                    (pwrite && (paddr != `TSR_ADDR_CTRL));
      end
   end

   // only the control register is writable; it steers units and point
   always @(posedge clk) begin
      if (!rst_b) begin
         ctrl <= `TSR_CTRL_RST;
      end else if (psel && penable && pwrite &&
                   (paddr == `TSR_ADDR_CTRL)) begin
         ctrl <= pwdata[3:0];
      end
   end

endmodule
`default_nettype wire

// *** sim/tsr_encoder_properties.sv ***
// concurrent checks on the encoder's link and status pins
`timescale 1ns/10ps
`default_nettype none
module tsr_encoder_props (
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic [9:0] slot_n,
   input wire logic [3:0] row_code,
   input wire logic [3:0] col_code,
   input wire logic [3:0] digit_n,
   input wire logic       thousand_n,
   input wire logic       over_n,
   input wire logic       minus_n,
   input wire logic       last_count,
   input wire logic       store_pulse
);
   // slots are judged only once they have cleared the synchroniser
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_idle;
      (&slot_n)[*4] |=> row_code == 4'h0 && col_code == 4'h0;
   endproperty
   a_idle: assert property (p_idle) else $error("codes not idle");
   property p_unused;
      (slot_n == 10'h3fd || slot_n == 10'h1ff)[*4] |=> {row_code, col_code} == 8'h00;
   endproperty
   a_unused: assert property (p_unused) else $error("unused slot coded");
   property p_dig_off;
      (slot_n[6:3] == 4'hf)[*4] |=> digit_n == 4'hf;
   endproperty
   a_dig_off: assert property (p_dig_off) else $error("digit out of slot");
   property p_zero;
      (slot_n == 10'h3f7)[*4] |=> row_code == (thousand_n ? 4'h8 : 4'h0);
   endproperty
   a_zero: assert property (p_zero) else $error("zero cancel wrong");
   property p_dcol;
      (slot_n == 10'h3f7)[*4] |=> col_code == ~digit_n;
   endproperty
   a_dcol: assert property (p_dcol) else $error("column not digit");
   property p_flags;
      !over_n |-> !thousand_n;
   endproperty
   a_flags: assert property (p_flags) else $error("flag order wrong");
   property p_held;
      !$stable({thousand_n, over_n, minus_n}) |-> store_pulse;
   endproperty
   a_held: assert property (p_held) else $error("flags moved alone");
   property p_lc;
      $rose(last_count) |-> last_count[*6] ##[1:4] !last_count;
   endproperty
   a_lc: assert property (p_lc) else $error("full count width");
   property p_store;
      store_pulse |=> !store_pulse;
   endproperty
   a_store: assert property (p_store) else $error("store too long");
endmodule
`default_nettype wire

// *** sim/tsr_readout_host.sv ***
// readout system model: ten slot strobes, codes sampled per slot
`timescale 1ns/10ps
`default_nettype none
module tsr_readout_host (
   input  wire logic            clk,
   input  wire logic            go,
   input  wire logic [3:0]      hold,
   input  wire logic [3:0]      row_code,
   input  wire logic [3:0]      col_code,
   input  wire logic [3:0]      digit_n,
   output var  logic [9:0]      slot_n,
   output var  logic            done,
   output var  logic [9:0][3:0] rows,
   output var  logic [9:0][3:0] cols,
   output var  logic [9:0][3:0] digs
);
   int k;
   // slots in order; lines pulled back high between strobes
   initial begin
      slot_n = 10'h3ff;
      done = 1'b0;
      forever begin
         @(posedge clk);
         if (go) begin
            for (k = 0; k < 10; k++) begin
               slot_n <= ~(10'h001 << k);
               repeat (hold) @(posedge clk);
               rows[k] <= row_code;
               cols[k] <= col_code;
               digs[k] <= digit_n;
               slot_n <= 10'h3ff;
               repeat (4) @(posedge clk);
            end
            done <= 1'b1;
            @(posedge clk);
            done <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// *** sim/tsr_encoder_tb.sv ***
// self-checking bench for the time slot readout encoder
`timescale 1ns/10ps
`default_nettype none
module tsr_encoder_tb;
   logic            clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
   logic            pwrite = 1'b0, meas_clk = 1'b0, zero_cross_n = 1'b1;
   logic            vx_neg = 1'b0, go = 1'b0, pready, pslverr, done, err;
   logic            thousand_n, over_n, minus_n, last_count, store_pulse;
   logic [7:0]      paddr = 8'h00;
   logic [31:0]     pwdata = 32'h0, prdata, rd;
   logic [3:0]      hold = 4'h5, row_code, col_code, digit_n;
   logic [9:0]      slot_n;
   logic [9:0][3:0] rows, cols, digs;
   int              failures = 0, num_checks = 0, edges = 0, stores = 0;
   int              lc_at, held, f = 0, r = 0;
   bit              meas_on = 1'b0, neg;

   tsr_encoder DUT (.clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .meas_clk(meas_clk),
      .zero_cross_n(zero_cross_n), .vx_neg(vx_neg), .slot_n(slot_n),
      .row_code(row_code), .col_code(col_code), .digit_n(digit_n),
      .thousand_n(thousand_n), .over_n(over_n), .minus_n(minus_n),
      .last_count(last_count), .store_pulse(store_pulse));
   tsr_readout_host u_host (.clk(clk), .go(go), .hold(hold),
      .row_code(row_code), .col_code(col_code), .digit_n(digit_n),
      .slot_n(slot_n), .done(done), .rows(rows), .cols(cols), .digs(digs));

   // 40 mhz clock; measurement clock free running, edges fall midway between clk rises
   always #12.5 clk = ~clk;
   always #100 if (meas_on) meas_clk = ~meas_clk;

   // reference count of measurement edges and event log
   always @(posedge meas_clk) edges <= (edges == 7999) ? 0 : edges + 1;
   always @(posedge last_count) lc_at = edges;
   always @(posedge clk) if (store_pulse === 1'b1) stores <= stores + 1;

   task automatic final_report;
      if (failures == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic time_out;
      failures++;
      final_report();
   endtask

   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask

   // expected {row, col, digit} for one slot under current ctrl
   function automatic logic [11:0] exp_slot(int s, int v, bit n);
      logic [3:0] c;
      logic [3:0] w;
      w = (s == 1 && v >= 2000) ? 4'h4 : (s == 4 && v < 1000) ? 4'h8 : 4'h0;
      case (s)
         1: c = 4'(1 + r);
         3: c = (f == 2) ? 4'h0 : (n ? 4'h2 : 4'h1);
         4: c = 4'(v / 1000);
         5: c = 4'(v / 100 % 10);
         6: c = 4'(v / 10 % 10);
         7: c = 4'(v % 10);
         8: c = (f == 3) ? 4'h7 : (f == 2) ? ((r >= 2) ? 4'h4 : 4'h0) :
                (r == 0) ? 4'h3 : ((f == 0) ? 4'h2 : 4'h0);
         9: c = (f == 1) ? 4'h5 : ((f == 2) ? 4'h6 : 4'h0);
         default: c = 4'h0;
      endcase
      return {w, c, (s >= 4 && s <= 7) ? ~c : 4'hf};
   endfunction

   function automatic logic [31:0] stat(int v, bit n);
      return {12'h000, 1'b0, ~n, v < 2000, v < 1000, 4'(v / 1000),
              4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
   endfunction

   // one apb transfer, result taken at the edge pready is seen
   task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) time_out();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wait_edges(input int e);
      int n;
      for (n = 0; edges != e; n++) begin
         if (n > 90000) time_out();
         @(posedge clk);
      end
   endtask

   // crossing dropped on the last clock edge before a counter edge, so
   // the strobe meets the advance and has to wait one clock for it
   task automatic zc;
      @(negedge meas_clk);
      repeat (4) @(posedge clk);
      zero_cross_n <= 1'b0;
      repeat (4) @(posedge clk);
      zero_cross_n <= 1'b1;
   endtask

   // one full readout frame, host speed drawn at random
   task automatic scan(input int v, input bit n);
      int k;
      hold <= 4'(5 + $urandom % 5);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      for (k = 0; k < 300 && done !== 1'b1; k++) @(posedge clk);
      if (done !== 1'b1) time_out();
      for (k = 0; k < 10; k++)
         chk({rows[k], cols[k], digs[k]}, exp_slot(k + 1, v, n));
   endtask

   initial begin
      void'($urandom(32'hd3bd8053));
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      apb(1'b0, 8'h00, 32'h0);
      chk({err, rd}, 33'h0);
      apb(1'b0, 8'h04, 32'h0);
      chk({err, rd}, {1'b0, stat(0, 1'b0)});
      apb(1'b1, 8'h04, 32'h5);
      chk({32'h0, err}, 33'h1);
      apb(1'b0, 8'h0c, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
      scan(0, 1'b0);
      meas_on = 1'b1;
      wait_edges(300);
      zc(); // not armed yet, must be ignored
      wait_edges(0);
      chk(33'(lc_at), 33'd7999);
      chk(33'(stores), 33'd0);
      held = 2000 + int'($urandom % 300);
      neg = 1'($urandom % 2);
      vx_neg <= neg;
      wait_edges(held);
      zc();
      held = held + 1; // the colliding edge lands before the capture
      repeat (6) @(posedge clk);
      chk(33'(stores), 33'd1);
      apb(1'b0, 8'h04, 32'h0);
      chk({1'b0, rd}, {1'b0, stat(held, neg)});
      for (f = 0; f < 4; f++)
         for (r = 0; r < 4; r++) begin
            apb(1'b1, 8'h00, 32'(r * 4 + f));
            scan(held, neg);
         end
      apb(1'b0, 8'h04, 32'h0);
      chk({1'b0, rd}, {1'b0, stat(held, neg)});
      final_report();
   end
endmodule

bind tsr_encoder tsr_encoder_props u_props (.clk(clk), .rst_b(rst_b),
   .slot_n(slot_n), .row_code(row_code), .col_code(col_code),
   .digit_n(digit_n), .thousand_n(thousand_n), .over_n(over_n),
   .minus_n(minus_n), .last_count(last_count), .store_pulse(store_pulse));
`default_nettype wire
